// ### src/comparator_pkg.sv
// Package of constants for the comparator control logic.
// Function
// - Raw result is high when positive input exceeds negative input.
// - Mux enabled and converter off: channel select picks negative input.
// - Mux disabled or converter on: negative pin feeds the comparator.
// - Disable bit 7 powers the comparator off; changeable any time.
// - Bandgap select bit 6 feeds bandgap to positive input, else pin.
// - Output bit 5 shows result after a one to two cycle synchronizer.
// - Flag bit 4 sets when an output event matches the irq mode.
// - Flag clears on vector execution or a written one; zero no effect.
// - Irq request needs flag, enable bit 3 and global enable.
// - Capture route bit 2 routes output to timer capture, else none.
// - Capture irq reaches processor only with capture irq enable set.
// - Mode bits: 00 toggle, 10 falling, 11 rising, 01 reserved.
package comparator_pkg;
    // ************************************************************
    // Register map (byte addresses)
    // ************************************************************
    localparam logic [11:0] CTRL_STATUS_OFS = 12'h000;
    localparam logic [11:0] MUX_CFG_OFS = 12'h004;
    localparam logic [11:0] IRQ_STATUS_OFS = 12'h008;
    localparam logic [11:0] IRQ_MASK_OFS = 12'h00C;
    // ************************************************************
    // Control/status field positions
    // ************************************************************
    localparam int DISABLE_BIT = 7;
    localparam int BANDGAP_BIT = 6;
    localparam int OUTPUT_BIT = 5;
    localparam int FLAG_BIT = 4;
    localparam int IRQ_EN_BIT = 3;
    localparam int CAPTURE_BIT = 2;
    localparam int MODE_HI_BIT = 1;
    localparam int MODE_LO_BIT = 0;
    // Mux config: bits 2:0 stored only (channel comes from channel_select), bit 3 mux enable
    localparam int MUX_EN_BIT = 3;
    // Wrapper irq status: bit 0 comparator event, bit 1 capture event
    localparam int EV_CMP_BIT = 0;
    localparam int EV_CAP_BIT = 1;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [3:0] MUX_RESET = 4'h0;
    localparam logic [1:0] IRQ_RESET = 2'h0;
    // ************************************************************
    // Interrupt modes
    // ************************************************************
    localparam logic [1:0] MODE_TOGGLE = 2'h0;
    localparam logic [1:0] MODE_RESERVED = 2'h1;
    localparam logic [1:0] MODE_FALL = 2'h2;
    localparam logic [1:0] MODE_RISE = 2'h3;
endpackage

// ### src/comparator_sync.sv
// Two-stage synchronizer for the analog comparator result.
module comparator_sync (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic async_in,
    output logic sync_out
);
    logic stage1_reg;
    // First stage read only by second stage
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            stage1_reg <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            stage1_reg <= async_in;
            sync_out <= stage1_reg;
        end
    end
endmodule // comparator_sync

// ### src/comparator_edge.sv
// Edge classifier for the synchronized comparator output.
module comparator_edge (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic level_in,
    input wire logic [1:0] mode,
    output logic event_hit,
    output logic prev_level
);
    wire rise = level_in & ~prev_level;
    wire fall = ~level_in & prev_level;
    // Reserved code selects nothing
    assign event_hit = (mode == comparator_pkg::MODE_TOGGLE) ? (rise | fall) :
                       (mode == comparator_pkg::MODE_FALL) ? fall :
                       (mode == comparator_pkg::MODE_RISE) ? rise :
                       1'b0;
    // Previous-cycle copy for edge comparison
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prev_level <= 1'b0;
        end else begin
            prev_level <= level_in;
        end
    end
endmodule // comparator_edge

// ### src/comparator_ctrl.sv
// Comparator control logic with APB register access.
module comparator_ctrl (
    input wire logic sys_clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Analog front end, digital view
    input wire logic converter_enable,
    input wire logic [2:0] channel_select,
    input wire logic raw_result,
    output logic neg_use_channel,
    output logic [2:0] neg_channel,
    output logic pos_use_bandgap,
    output logic comparator_power_off,
    // Processor interrupt side
    input wire logic global_irq_enable,
    input wire logic vector_ack,
    output logic comparator_irq_req,
    // Timer capture side
    input wire logic capture_irq_enable,
    input wire logic capture_event,
    output logic capture_input,
    output logic capture_irq_req,
    // Wrapper interrupt
    output logic irq
);
    // ************************************************************
    // State
    // ************************************************************
    logic [7:0] ctrl_reg;
    logic [3:0] mux_reg;
    logic [1:0] ev_status_reg;
    logic [1:0] ev_mask_reg;
    logic flag_next;
    logic [1:0] ev_status_next;
    logic cmp_sync;
    logic cmp_prev;
    logic cmp_event;
    logic cap_sync;
    logic cap_prev;
    logic cap_irq_live;
    logic [31:0] read_mux;

    // ************************************************************
    // Comparator input path
    // ************************************************************
    // Raw result is already the analog decision of pos > neg
    comparator_sync sync_u (
        .sys_clk(sys_clk),
        .rst(rst),
        .async_in(raw_result),
        .sync_out(cmp_sync)
    );
    comparator_edge edge_u (
        .sys_clk(sys_clk),
        .rst(rst),
        .level_in(cmp_sync),
        .mode(ctrl_reg[comparator_pkg::MODE_HI_BIT:
                       comparator_pkg::MODE_LO_BIT]),
        .event_hit(cmp_event),
        .prev_level(cmp_prev)
    );
    // Capture event comes from the timer clock domain, equally synced
    comparator_sync cap_sync_u (
        .sys_clk(sys_clk),
        .rst(rst),
        .async_in(capture_event),
        .sync_out(cap_sync)
    );

    // ************************************************************
    // Bus decode
    // ************************************************************
    wire access = psel & penable;
    wire wr = access & pwrite;
    wire hit_ctrl = paddr == comparator_pkg::CTRL_STATUS_OFS;
    wire hit_mux = paddr == comparator_pkg::MUX_CFG_OFS;
    wire hit_st = paddr == comparator_pkg::IRQ_STATUS_OFS;
    wire hit_mask = paddr == comparator_pkg::IRQ_MASK_OFS;
    wire mapped = hit_ctrl | hit_mux | hit_st | hit_mask;
    wire wr_ctrl = wr & hit_ctrl;
    wire wr_mux = wr & hit_mux;
    wire wr_st = wr & hit_st;
    wire wr_mask = wr & hit_mask;
    wire flag_w1c = wr_ctrl & pwdata[comparator_pkg::FLAG_BIT];
    wire mux_active = mux_reg[comparator_pkg::MUX_EN_BIT] &
                      ~converter_enable;
    wire cap_rise = cap_sync & ~cap_prev;
    // Live status byte: output bit is the synchronized result
    wire [7:0] ctrl_view = {ctrl_reg[7:6], cmp_sync, ctrl_reg[4:0]};
    assign read_mux = hit_ctrl ? {24'h000000, ctrl_view} :
                      hit_mux ? {28'h0000000, mux_reg} :
                      hit_st ? {30'h0, ev_status_reg} :
                      hit_mask ? {30'h0, ev_mask_reg} :
                      32'h00000000;
    assign cap_irq_live = cap_sync & capture_irq_enable;

    // ************************************************************
    // Flag and event status next values
    // ************************************************************
    // Set beats clear so an event in the clearing cycle is kept
    always_comb begin
        flag_next = ctrl_reg[comparator_pkg::FLAG_BIT];
        if (flag_w1c | vector_ack) begin
            flag_next = 1'b0;
        end
        if (cmp_event) begin
            flag_next = 1'b1;
        end
        ev_status_next = ev_status_reg;
        if (wr_st) begin
            ev_status_next = ev_status_reg & ~pwdata[1:0];
        end
        if (cmp_event) begin
            ev_status_next[comparator_pkg::EV_CMP_BIT] = 1'b1;
        end
        if (cap_rise & ctrl_reg[comparator_pkg::CAPTURE_BIT]) begin
            ev_status_next[comparator_pkg::EV_CAP_BIT] = 1'b1;
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    // Writable bits start at zero; flag is written only via w1c
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctrl_reg <= comparator_pkg::CTRL_RESET;
            mux_reg <= comparator_pkg::MUX_RESET;
            ev_status_reg <= comparator_pkg::IRQ_RESET;
            ev_mask_reg <= comparator_pkg::IRQ_RESET;
            cap_prev <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg[7:6] <= pwdata[7:6];
                ctrl_reg[3:0] <= pwdata[3:0];
            end
            ctrl_reg[comparator_pkg::FLAG_BIT] <= flag_next;
            ctrl_reg[comparator_pkg::OUTPUT_BIT] <= 1'b0;
            if (wr_mux) begin
                mux_reg <= pwdata[3:0];
            end
            if (wr_mask) begin
                ev_mask_reg <= pwdata[1:0];
            end
            ev_status_reg <= ev_status_next;
            cap_prev <= cap_sync;
        end
    end

    // ************************************************************
    // Registered outputs
    // ************************************************************
    // Zero-wait APB; unmapped addresses answer with pslverr
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
            prdata <= (psel & ~penable & ~pwrite) ? read_mux : 32'h00000000;
        end
    end
    // Analog steering and interrupt requests, one cycle after the cause
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            neg_use_channel <= 1'b0;
            neg_channel <= 3'h0;
            pos_use_bandgap <= 1'b0;
            comparator_power_off <= 1'b0;
            comparator_irq_req <= 1'b0;
            capture_input <= 1'b0;
            capture_irq_req <= 1'b0;
            irq <= 1'b0;
        end else begin
            neg_use_channel <= mux_active;
            neg_channel <= mux_active ? channel_select : 3'h0;
            pos_use_bandgap <= ctrl_reg[comparator_pkg::BANDGAP_BIT];
            comparator_power_off <=
                ctrl_reg[comparator_pkg::DISABLE_BIT];
            comparator_irq_req <= ctrl_reg[comparator_pkg::FLAG_BIT] &
                ctrl_reg[comparator_pkg::IRQ_EN_BIT] &
                global_irq_enable;
            capture_input <= ctrl_reg[comparator_pkg::CAPTURE_BIT] &
                cmp_sync;
            capture_irq_req <= cap_irq_live &
                ctrl_reg[comparator_pkg::CAPTURE_BIT];
            irq <= |(ev_status_reg & ev_mask_reg);
        end
    end
endmodule // comparator_ctrl

// ### verif/comparator_ctrl_checker.sv
// Checker of port timing for the comparator control logic.
module comparator_checker (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic converter_enable,
    input wire logic [2:0] channel_select,
    input wire logic raw_result,
    input wire logic neg_use_channel,
    input wire logic [2:0] neg_channel,
    input wire logic pos_use_bandgap,
    input wire logic comparator_power_off,
    input wire logic global_irq_enable,
    input wire logic comparator_irq_req,
    input wire logic capture_irq_enable,
    input wire logic capture_input,
    input wire logic capture_irq_req
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Setup is answered in the very next cycle
    chk_pready_answer: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    chk_pready_idle: assert property (!psel |=> !pready)
        else $error("answer without request");
    // Only the four words are mapped
    chk_slverr_unmapped: assert property (psel && !penable && paddr[11:4] != 0
        |=> pslverr && pready) else $error("unmapped not refused");
    // Register commits at the access edge, output follows one edge later
    chk_power_off: assert property (
        psel && penable && pwrite && pready && paddr == 12'h000
        |-> ##2 comparator_power_off == $past(pwdata[7], 2))
        else $error("disable bit not applied");
    chk_bandgap_sel: assert property (
        psel && penable && pwrite && pready && paddr == 12'h000
        |-> ##2 pos_use_bandgap == $past(pwdata[6], 2))
        else $error("bandgap bit not applied");
    // Channel feeds the negative input only with the converter off
    chk_neg_route: assert property (
        neg_use_channel |-> !$past(converter_enable)
        && neg_channel == $past(channel_select))
        else $error("channel routed wrongly");
    chk_neg_pin: assert property (
        !neg_use_channel |-> neg_channel == 3'h0)
        else $error("channel shown while pin used");
    // Requests need their enables
    chk_irq_global: assert property (
        !$past(global_irq_enable) |-> !comparator_irq_req)
        else $error("irq while global off");
    chk_capture_gate: assert property (
        capture_irq_req |-> $past(capture_irq_enable))
        else $error("capture irq ungated");
    // Capture path follows the synchronized result
    chk_capture_sync: assert property (
        $rose(capture_input)
        |-> $past(raw_result, 2) || $past(raw_result, 3))
        else $error("capture input not from result");
endmodule // comparator_checker
bind comparator_ctrl comparator_checker chk (
    .sys_clk(sys_clk),
    .rst(rst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pready(pready),
    .pslverr(pslverr),
    .converter_enable(converter_enable),
    .channel_select(channel_select),
    .raw_result(raw_result),
    .neg_use_channel(neg_use_channel),
    .neg_channel(neg_channel),
    .pos_use_bandgap(pos_use_bandgap),
    .comparator_power_off(comparator_power_off),
    .global_irq_enable(global_irq_enable),
    .comparator_irq_req(comparator_irq_req),
    .capture_irq_enable(capture_irq_enable),
    .capture_input(capture_input),
    .capture_irq_req(capture_irq_req)
);

// ### verif/tb.sv
// Self-checking testbench for the comparator control logic.
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk, rst, psel, penable, pwrite, conv, raw, glob, vack, cie, cev;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, v;
    logic [2:0] chs;
    logic pready, pslverr, nuse, pbg, poff, creq, cin, capreq, irq, er;
    logic [2:0] nch;
    int n_mismatch = 0, samples_checked = 0;
    comparator_ctrl dut (.sys_clk(sys_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .converter_enable(conv), .channel_select(chs), .raw_result(raw),
        .neg_use_channel(nuse), .neg_channel(nch), .pos_use_bandgap(pbg),
        .comparator_power_off(poff), .global_irq_enable(glob),
        .vector_ack(vack), .comparator_irq_req(creq),
        .capture_irq_enable(cie), .capture_event(cev), .capture_input(cin),
        .capture_irq_req(capreq), .irq(irq));
    // ************************************************************
    // Clock, compare and bus tasks
    // ************************************************************
    initial begin
        sys_clk = 0;
        forever #25 sys_clk = ~sys_clk;
    end
    task automatic cmp(input logic [31:0] got, exp, input string m);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask
    task automatic give_verdict();
        $display("checked %0d, mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // One transfer; bus released one cycle before the next may start
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge sys_clk);
        penable <= 1;
        n = 0;
        do begin @(posedge sys_clk); n++; end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin n_mismatch++; give_verdict(); end
        rd = prdata; er = pslverr;
        psel <= 0; penable <= 0;
        @(posedge sys_clk);
    endtask
    task automatic wt(input int c);
        repeat (c) @(posedge sys_clk);
    endtask
    function automatic logic want_flag(logic [1:0] m, logic rise);
        return m == 2'h0 || (m == 2'h3 && rise) || (m == 2'h2 && !rise);
    endfunction
    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        {psel, penable, pwrite, conv, raw, glob, vack, cie, cev} = '0;
        paddr = '0; pwdata = '0; chs = '0; rst = 1;
        void'($urandom(32'hADD2));
        wt(2);
        rst <= 0;
        apb(0, 12'h000, 0); cmp(rd & 32'hDF, 0, "ctrl reset");
        apb(0, 12'h004, 0); cmp(rd, 0, "mux reset");
        apb(0, 12'h010, 0);
        cmp({31'h0, er}, 32'h1, "unmapped refused");
        cmp(rd, 0, "unmapped read");
        $display("test reset done");
        // Random control values; output bit is read-only
        repeat (4) begin
            v = $urandom & 32'hE7;
            // Irq enable stays clear while the disable bit moves
            apb(1, 12'h000, v);
            apb(0, 12'h000, 0);
            cmp(rd & 32'hDF, v & 32'hC7, "ctrl readback");
            cmp({poff, pbg}, v[7:6], "analog controls");
        end
        $display("test control done");
        // Negative input selection
        repeat (6) begin
            v = $urandom;
            conv <= v[0]; chs <= v[3:1];
            apb(1, 12'h004, {28'h0, v[4], 3'h0}); wt(2);
            cmp(nuse, v[4] & !v[0], "neg select");
            cmp(nch, (v[4] & !v[0]) ? v[3:1] : 3'h0, "neg channel");
        end
        conv <= 0;
        $display("test mux done");
        // Every mode code against a rise then a fall
        for (int i = 0; i < 4; i++) begin
            apb(1, 12'h000, {30'h0, 2'(i)});
            for (int e = 1; e >= 0; e--) begin
                raw <= e[0]; wt(5);
                apb(0, 12'h000, 0);
                cmp(rd[5:4], {e[0], want_flag(2'(i), e[0])}, "flag");
                apb(1, 12'h000, {26'h0, 2'h1, 2'h0, 2'(i)}); apb(0, 12'h000, 0);
                cmp(rd[4], 0, "flag w1c");
            end
        end
        $display("test modes done");
        // Interrupt request, vector clear, wrapper status and mask
        // Old events are cleared first so the sticky bit proves a new one
        apb(1, 12'h008, 3);
        apb(1, 12'h00C, 1);
        glob <= 1;
        wt(1);
        cmp(irq, 0, "status cleared");
        // Mode moves while the enable is still clear
        apb(1, 12'h000, 32'h04);
        apb(1, 12'h000, 32'h0C);
        raw <= 1;
        wt(6);
        cmp({creq, irq, cin}, 3'h7, "irq raised");
        vack <= 1; wt(1); vack <= 0; wt(2);
        cmp(creq, 0, "vector clear");
        apb(1, 12'h00C, 0);
        wt(1);
        cmp(irq, 0, "masked");
        apb(0, 12'h008, 0); cmp(rd[0], 1, "event sticky");
        apb(1, 12'h008, 1); apb(0, 12'h008, 0); cmp(rd[0], 0, "event w1c");
        cie <= 1; cev <= 1; wt(5);
        cmp(capreq, 1, "capture irq");
        cie <= 0; wt(2); cmp(capreq, 0, "capture masked");
        apb(0, 12'h008, 0);
        cmp(rd[1:0], 2'h2, "capture event");
        $display("test irq done");
        give_verdict();
    end
endmodule // tb
